// ---- gsr_params.svh ----
// Register offsets, field positions, reset values and command codes.
`ifndef GSR_PARAMS_SVH
`define GSR_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define GSR_OFF_MODE_SEL 8'h10
`define GSR_OFF_COMMAND 8'h12
`define GSR_OFF_TEMP_LO 8'h13
`define GSR_OFF_TEMP_HI 8'h14
`define GSR_OFF_HUM_LO 8'h15
`define GSR_OFF_HUM_HI 8'h16
`define GSR_OFF_STATE 8'h20
`define GSR_OFF_AIR5 8'h21
`define GSR_OFF_ORGANIC 8'h22
`define GSR_OFF_ORGANIC_HI 8'h23
`define GSR_OFF_CO2 8'h24
`define GSR_OFF_CO2_HI 8'h25
`define GSR_OFF_RELAQ 8'h26
`define GSR_OFF_DATA_LAST 8'h27
`define GSR_OFF_READBACK 8'h48
`define GSR_OFF_READBACK_LAST 8'h4f
`define GSR_READBACK_NUM 8
`define GSR_READBACK_IDX_W 3

// ****************************************************************
// Readback byte slots for the version answer
// ****************************************************************
`define GSR_RB_MAJOR 3'h4
`define GSR_RB_MINOR 3'h5
`define GSR_RB_RELEASE 3'h6

// ****************************************************************
// Command and mode codes
// ****************************************************************
`define GSR_CMD_NOP 8'h00
`define GSR_CMD_VERSION 8'h0e
`define GSR_CMD_CLEAR 8'hcc
`define GSR_MODE_IDLE 8'h01

// ****************************************************************
// Status byte bit positions and reset values
// ****************************************************************
`define GSR_ST_RUNNING 7
`define GSR_ST_ERROR 6
`define GSR_ST_VALID_HI 3
`define GSR_ST_VALID_LO 2
`define GSR_ST_OUT_NEW 1
`define GSR_ST_RB_NEW 0
`define GSR_AIR5_RESET 3'h1
`define GSR_WORD_RESET 16'h0000
`define GSR_BYTE_RESET 8'h00

`endif

// ---- gsr_pkg.sv ----
// Shared types for both ends of the sensor register link.
package gsr_pkg;

	// Host sequencer states.
	typedef enum logic [2:0]
	{
		gsr_h_idle,
		gsr_h_first,
		gsr_h_wait_first,
		gsr_h_second,
		gsr_h_wait_second
	} gsr_host_state_e;

	typedef logic [7:0] gsr_byte_t;

endpackage

// ---- gsr_link_if.sv ----
// Byte-wide register link between the host and the sensor.
interface gsr_link_if;
	logic [7:0] bus_addr;
	logic bus_wr;
	logic bus_rd;
	logic [7:0] bus_wdata;
	logic [7:0] bus_rdata;
	logic bus_ack;
	logic host_interrupt_pin;

	modport device
	(
		input bus_addr,
		input bus_wr,
		input bus_rd,
		input bus_wdata,
		output bus_rdata,
		output bus_ack,
		output host_interrupt_pin
	);

	modport host
	(
		output bus_addr,
		output bus_wr,
		output bus_rd,
		output bus_wdata,
		input bus_rdata,
		input bus_ack,
		input host_interrupt_pin
	);
endinterface

// ---- gsr_device.sv ----
// Sensor-side result register bank with command handling.
`include "gsr_params.svh"

module gsr_device
	import gsr_pkg::*;
#(
	parameter logic [7:0] VERSION_MAJOR = 8'h01, // Arbitrary value.
	parameter logic [7:0] VERSION_MINOR = 8'h00, // Arbitrary value.
	parameter logic [7:0] VERSION_RELEASE = 8'h00 // Arbitrary value.
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	gsr_link_if.device link,
	input wire logic [7:0] operating_mode_select,
	input wire logic mode_running,
	input wire logic error_detected,
	input wire logic [1:0] output_validity,
	input wire logic results_load,
	input wire logic [2:0] five_level_air_index,
	input wire logic [15:0] organic_compound_level,
	input wire logic [15:0] carbon_dioxide_equivalent,
	input wire logic [15:0] relative_air_index,
	input wire logic irq_enable,
	input wire logic irq_on_readback,
	input wire logic irq_on_output,
	input wire logic irq_active_high,
	output logic [15:0] ambient_temperature_input,
	output logic temperature_update,
	output logic [15:0] ambient_humidity_input,
	output logic humidity_update
);

	// ****************************************************************
	// State
	// ****************************************************************
	gsr_byte_t command_reg, command_next;
	logic command_pending_reg, command_pending_next;
	gsr_byte_t temp_lo_reg, temp_lo_next;
	logic [15:0] temp_reg, temp_next;
	logic temp_upd_reg, temp_upd_next;
	gsr_byte_t hum_lo_reg, hum_lo_next;
	logic [15:0] hum_reg, hum_next;
	logic hum_upd_reg, hum_upd_next;
	gsr_byte_t rb_reg [`GSR_READBACK_NUM];
	gsr_byte_t rb_next [`GSR_READBACK_NUM];
	logic rb_new_reg, rb_new_next;
	logic out_new_reg, out_new_next;
	logic [2:0] air5_reg, air5_next;
	logic [15:0] organic_reg, organic_next;
	logic [15:0] co2_reg, co2_next;
	logic [15:0] relaq_reg, relaq_next;
	gsr_byte_t status_reg, status_next;
	gsr_byte_t rdata_reg, rdata_next;
	logic ack_reg, ack_next;
	logic irq_reg, irq_next;
	logic rb_loaded;
	logic rd_data_hit;
	logic rd_rb_hit;
	gsr_byte_t read_mux;

	// Address windows whose reads clear the new flags.
	assign rd_data_hit = link.bus_rd &&
		link.bus_addr >= `GSR_OFF_AIR5 &&
		link.bus_addr <= `GSR_OFF_DATA_LAST;
	assign rd_rb_hit = link.bus_rd &&
		link.bus_addr >= `GSR_OFF_READBACK &&
		link.bus_addr <= `GSR_OFF_READBACK_LAST;

	// Read multiplexer; unmapped offsets read as zero.
	always_comb
	begin
		read_mux = `GSR_BYTE_RESET;
		case (link.bus_addr)
			`GSR_OFF_COMMAND: read_mux = command_reg;
			`GSR_OFF_TEMP_LO: read_mux = temp_lo_reg;
			`GSR_OFF_TEMP_HI: read_mux = temp_reg[15:8];
			`GSR_OFF_HUM_LO: read_mux = hum_lo_reg;
			`GSR_OFF_HUM_HI: read_mux = hum_reg[15:8];
			`GSR_OFF_STATE: read_mux = status_reg;
			`GSR_OFF_AIR5: read_mux = {5'h00, air5_reg};
			`GSR_OFF_ORGANIC: read_mux = organic_reg[7:0];
			`GSR_OFF_ORGANIC_HI: read_mux = organic_reg[15:8];
			`GSR_OFF_CO2: read_mux = co2_reg[7:0];
			`GSR_OFF_CO2_HI: read_mux = co2_reg[15:8];
			`GSR_OFF_RELAQ: read_mux = relaq_reg[7:0];
			`GSR_OFF_DATA_LAST: read_mux = relaq_reg[15:8];
			default:
			begin
				if (rd_rb_hit)
					read_mux = rb_reg[link.bus_addr[`GSR_READBACK_IDX_W-1:0]];
			end
		endcase
	end

	// Command latch: a write is always taken, but it runs only in idle
	// mode, so a command written during sensing waits for idle.
	always_comb
	begin
		command_next = command_reg;
		command_pending_next = command_pending_reg;
		rb_loaded = 1'b0;
		for (int i = 0; i < `GSR_READBACK_NUM; i++)
			rb_next[i] = rb_reg[i];
		if (command_pending_reg &&
			operating_mode_select == `GSR_MODE_IDLE)
		begin
			command_pending_next = 1'b0;
			case (command_reg)
				`GSR_CMD_VERSION:
				begin
					rb_next[`GSR_RB_MAJOR] = VERSION_MAJOR;
					rb_next[`GSR_RB_MINOR] = VERSION_MINOR;
					rb_next[`GSR_RB_RELEASE] = VERSION_RELEASE;
					rb_loaded = 1'b1;
				end
				`GSR_CMD_CLEAR:
				begin
					for (int i = 0; i < `GSR_READBACK_NUM; i++)
						rb_next[i] = `GSR_BYTE_RESET;
				end
				default:
				begin
				end
			endcase
		end
		if (link.bus_wr && link.bus_addr == `GSR_OFF_COMMAND)
		begin
			command_next = link.bus_wdata;
			command_pending_next = 1'b1;
		end
	end

	// Compensation inputs: the low byte is staged, the high byte write
	// commits both halves so the core never sees a torn value.
	always_comb
	begin
		temp_lo_next = temp_lo_reg;
		temp_next = temp_reg;
		temp_upd_next = 1'b0;
		hum_lo_next = hum_lo_reg;
		hum_next = hum_reg;
		hum_upd_next = 1'b0;
		if (link.bus_wr)
		begin
			case (link.bus_addr)
				`GSR_OFF_TEMP_LO: temp_lo_next = link.bus_wdata;
				`GSR_OFF_TEMP_HI:
				begin
					temp_next = {link.bus_wdata, temp_lo_reg};
					temp_upd_next = 1'b1;
				end
				`GSR_OFF_HUM_LO: hum_lo_next = link.bus_wdata;
				`GSR_OFF_HUM_HI:
				begin
					hum_next = {link.bus_wdata, hum_lo_reg};
					hum_upd_next = 1'b1;
				end
				default:
				begin
				end
			endcase
		end
	end

	// Results, flags, status and answer. A set in the same cycle as a
	// clearing read wins, so a fresh result is never silently lost.
	always_comb
	begin
		air5_next = air5_reg;
		organic_next = organic_reg;
		co2_next = co2_reg;
		relaq_next = relaq_reg;
		if (results_load)
		begin
			air5_next = five_level_air_index;
			organic_next = organic_compound_level;
			co2_next = carbon_dioxide_equivalent;
			relaq_next = relative_air_index;
		end
		out_new_next = results_load ||
			(out_new_reg && !rd_data_hit);
		rb_new_next = rb_loaded || (rb_new_reg && !rd_rb_hit);
		status_next = `GSR_BYTE_RESET;
		status_next[`GSR_ST_RUNNING] = mode_running;
		status_next[`GSR_ST_ERROR] = error_detected;
		status_next[`GSR_ST_VALID_HI:`GSR_ST_VALID_LO] =
			output_validity;
		status_next[`GSR_ST_OUT_NEW] = out_new_next;
		status_next[`GSR_ST_RB_NEW] = rb_new_next;
		rdata_next = link.bus_rd ? read_mux : rdata_reg;
		ack_next = link.bus_rd || link.bus_wr;
		irq_next = irq_enable &&
			((irq_on_readback && rb_new_next) ||
			(irq_on_output && out_new_next));
		irq_next = irq_next ~^ irq_active_high;
	end

	// Register stage for all state.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			command_reg <= `GSR_CMD_NOP;
			command_pending_reg <= 1'b0;
			temp_lo_reg <= `GSR_BYTE_RESET;
			temp_reg <= `GSR_WORD_RESET;
			temp_upd_reg <= 1'b0;
			hum_lo_reg <= `GSR_BYTE_RESET;
			hum_reg <= `GSR_WORD_RESET;
			hum_upd_reg <= 1'b0;
			for (int i = 0; i < `GSR_READBACK_NUM; i++)
				rb_reg[i] <= `GSR_BYTE_RESET;
			rb_new_reg <= 1'b0;
			out_new_reg <= 1'b0;
			air5_reg <= `GSR_AIR5_RESET;
			organic_reg <= `GSR_WORD_RESET;
			co2_reg <= `GSR_WORD_RESET;
			relaq_reg <= `GSR_WORD_RESET;
			status_reg <= `GSR_BYTE_RESET;
			rdata_reg <= `GSR_BYTE_RESET;
			ack_reg <= 1'b0;
			irq_reg <= 1'b1; // Inactive for the default low polarity.
		end
		else
		begin
			command_reg <= command_next;
			command_pending_reg <= command_pending_next;
			temp_lo_reg <= temp_lo_next;
			temp_reg <= temp_next;
			temp_upd_reg <= temp_upd_next;
			hum_lo_reg <= hum_lo_next;
			hum_reg <= hum_next;
			hum_upd_reg <= hum_upd_next;
			for (int i = 0; i < `GSR_READBACK_NUM; i++)
				rb_reg[i] <= rb_next[i];
			rb_new_reg <= rb_new_next;
			out_new_reg <= out_new_next;
			air5_reg <= air5_next;
			organic_reg <= organic_next;
			co2_reg <= co2_next;
			relaq_reg <= relaq_next;
			status_reg <= status_next;
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
			irq_reg <= irq_next;
		end
	end

	// Output drive, all straight from flip-flops.
	assign link.bus_rdata = rdata_reg;
	assign link.bus_ack = ack_reg;
	assign link.host_interrupt_pin = irq_reg;
	assign ambient_temperature_input = temp_reg;
	assign temperature_update = temp_upd_reg;
	assign ambient_humidity_input = hum_reg;
	assign humidity_update = hum_upd_reg;

endmodule // gsr_device

// ---- gsr_host.sv ----
// Host-side sequencer issuing byte and little-endian word accesses.
`include "gsr_params.svh"

module gsr_host
	import gsr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	gsr_link_if.host link,
	input wire logic req,
	input wire logic req_write,
	input wire logic req_wide,
	input wire logic [7:0] req_addr,
	input wire logic [15:0] req_wdata,
	output logic busy,
	output logic done,
	output logic [15:0] rsp_rdata,
	output logic interrupt_seen
);

	// ****************************************************************
	// Sequencer state
	// ****************************************************************
	gsr_host_state_e state_reg, state_next;
	logic write_reg, write_next;
	logic wide_reg, wide_next;
	logic [7:0] addr_reg, addr_next;
	logic [15:0] data_reg, data_next;
	logic [7:0] bus_addr_reg, bus_addr_next;
	logic bus_wr_reg, bus_wr_next;
	logic bus_rd_reg, bus_rd_next;
	logic [7:0] bus_wdata_reg, bus_wdata_next;
	logic done_reg, done_next;
	logic irq_reg;

	// Word accesses go low byte first so the device commits a whole
	// value on the high byte; the high byte sits at the next offset.
	always_comb
	begin
		state_next = state_reg;
		write_next = write_reg;
		wide_next = wide_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		bus_addr_next = bus_addr_reg;
		bus_wr_next = 1'b0;
		bus_rd_next = 1'b0;
		bus_wdata_next = bus_wdata_reg;
		done_next = 1'b0;
		case (state_reg)
			gsr_h_idle:
			begin
				if (req)
				begin
					write_next = req_write;
					wide_next = req_wide;
					addr_next = req_addr;
					data_next = req_write ? req_wdata : `GSR_WORD_RESET;
					state_next = gsr_h_first;
				end
			end
			gsr_h_first:
			begin
				bus_addr_next = addr_reg;
				bus_wr_next = write_reg;
				bus_rd_next = !write_reg;
				bus_wdata_next = data_reg[7:0];
				state_next = gsr_h_wait_first;
			end
			gsr_h_wait_first:
			begin
				if (link.bus_ack)
				begin
					if (!write_reg)
						data_next[7:0] = link.bus_rdata;
					if (wide_reg)
						state_next = gsr_h_second;
					else
					begin
						done_next = 1'b1;
						state_next = gsr_h_idle;
					end
				end
			end
			gsr_h_second:
			begin
				bus_addr_next = addr_reg + 8'h01;
				bus_wr_next = write_reg;
				bus_rd_next = !write_reg;
				bus_wdata_next = data_reg[15:8];
				state_next = gsr_h_wait_second;
			end
			gsr_h_wait_second:
			begin
				if (link.bus_ack)
				begin
					if (!write_reg)
						data_next[15:8] = link.bus_rdata;
					done_next = 1'b1;
					state_next = gsr_h_idle;
				end
			end
			default: state_next = gsr_h_idle;
		endcase
	end

	// Register stage; the interrupt pin is only sampled for the user.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg <= gsr_h_idle;
			write_reg <= 1'b0;
			wide_reg <= 1'b0;
			addr_reg <= `GSR_BYTE_RESET;
			data_reg <= `GSR_WORD_RESET;
			bus_addr_reg <= `GSR_BYTE_RESET;
			bus_wr_reg <= 1'b0;
			bus_rd_reg <= 1'b0;
			bus_wdata_reg <= `GSR_BYTE_RESET;
			done_reg <= 1'b0;
			irq_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			write_reg <= write_next;
			wide_reg <= wide_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			bus_addr_reg <= bus_addr_next;
			bus_wr_reg <= bus_wr_next;
			bus_rd_reg <= bus_rd_next;
			bus_wdata_reg <= bus_wdata_next;
			done_reg <= done_next;
			irq_reg <= link.host_interrupt_pin;
		end
	end

	// Link and user outputs from flip-flops.
	assign link.bus_addr = bus_addr_reg;
	assign link.bus_wr = bus_wr_reg;
	assign link.bus_rd = bus_rd_reg;
	assign link.bus_wdata = bus_wdata_reg;
	assign busy = (state_reg != gsr_h_idle);
	assign done = done_reg;
	assign rsp_rdata = data_reg;
	assign interrupt_seen = irq_reg;

endmodule // gsr_host

// ---- gsr_props.sv ----
// Checker for the byte link between the host and the sensor ends.
`include "gsr_params.svh"

module gsr_props
	import gsr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_ack,
	input wire logic host_interrupt_pin
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************
	// Link properties
	// ****************
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// Read strobes by address class, used to build the flag-clear steps.
	sequence s_rb_rd;
		bus_rd && bus_addr >= 8'h48 && bus_addr <= 8'h4f;
	endsequence
	sequence s_dat_rd;
		bus_rd && bus_addr >= 8'h21 && bus_addr <= 8'h27;
	endsequence
	sequence s_st_rd;
		bus_rd && bus_addr == `GSR_OFF_STATE;
	endsequence

	a_ack_follows: assert property ((bus_wr || bus_rd) |=> bus_ack)
		else $error("ack missing after strobe");
	a_ack_has_cause: assert property (bus_ack |-> $past(bus_wr || bus_rd))
		else $error("ack without strobe");
	a_strobe_excl: assert property (!(bus_wr && bus_rd))
		else $error("write and read strobes together");
	a_state_reserved: assert property (s_st_rd |=> bus_rdata[5:4] == 2'b00)
		else $error("status reserved bits set");
	a_air_reserved: assert property (bus_rd && bus_addr == 8'h21
		|=> bus_rdata[7:3] == 5'h00 && bus_rdata[2:0] != 3'h0)
		else $error("air index reserved bits or zero index");
	a_rb_flag_clear: assert property (s_rb_rd ##[1:6] s_st_rd |=> !bus_rdata[0])
		else $error("readback flag not cleared by read");
	a_out_flag_clear: assert property (s_dat_rd ##[1:6] s_st_rd |=> !bus_rdata[1])
		else $error("output flag not cleared by read");
	a_temp_staged: assert property (bus_wr && bus_addr == 8'h13 ##5
		bus_rd && bus_addr == 8'h13 |=> bus_rdata == $past(bus_wdata, 6))
		else $error("staged temperature low byte lost");
	a_hum_commit: assert property (bus_wr && bus_addr == 8'h16 ##5
		bus_rd && bus_addr == 8'h16 |=> bus_rdata == $past(bus_wdata, 6))
		else $error("committed humidity high byte lost");
	a_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
		else $error("read data changed without a read");
endmodule // gsr_props

// ---- tb.sv ----
// Self-checking bench joining the host and sensor ends over the link.
`include "gsr_params.svh"

module tb;
	import gsr_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	// Version values are arbitrary.
	localparam logic [7:0] VMAJ = 8'h03;
	localparam logic [7:0] VMIN = 8'h02;
	localparam logic [7:0] VREL = 8'h05;

	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] mode_sel = 8'h02;
	logic run = 1'b0;
	logic err = 1'b0;
	logic [1:0] vld = 2'b00;
	logic rload = 1'b0;
	logic [2:0] air = 3'h1;
	logic [15:0] org = 16'h0000;
	logic [15:0] co2 = 16'h0000;
	logic [15:0] rel = 16'h0000;
	logic irq_en = 1'b1;
	logic irq_rb = 1'b1;
	logic irq_out = 1'b0;
	logic irq_hi = 1'b1;
	logic [15:0] temp_out;
	logic temp_upd;
	logic [15:0] hum_out;
	logic hum_upd;
	logic req = 1'b0;
	logic req_write = 1'b0;
	logic req_wide = 1'b0;
	logic [7:0] req_addr = 8'h00;
	logic [15:0] req_wdata = 16'h0000;
	logic busy;
	logic done;
	logic [15:0] rsp_rdata;
	logic irq_seen;
	logic [15:0] v;
	int n_errors = 0;
	int checks = 0;
	int n_tu = 0;
	int n_hu = 0;

	gsr_link_if lk();

	gsr_device #(.VERSION_MAJOR(VMAJ), .VERSION_MINOR(VMIN),
		.VERSION_RELEASE(VREL)) u_gsr_device (.core_clk(core_clk),
		.rst_b(rst_b), .link(lk), .operating_mode_select(mode_sel),
		.mode_running(run), .error_detected(err), .output_validity(vld),
		.results_load(rload), .five_level_air_index(air),
		.organic_compound_level(org), .carbon_dioxide_equivalent(co2),
		.relative_air_index(rel), .irq_enable(irq_en),
		.irq_on_readback(irq_rb), .irq_on_output(irq_out),
		.irq_active_high(irq_hi), .ambient_temperature_input(temp_out),
		.temperature_update(temp_upd), .ambient_humidity_input(hum_out),
		.humidity_update(hum_upd));

	gsr_host u_gsr_host (.core_clk(core_clk), .rst_b(rst_b), .link(lk),
		.req(req), .req_write(req_write), .req_wide(req_wide),
		.req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
		.done(done), .rsp_rdata(rsp_rdata), .interrupt_seen(irq_seen));

	gsr_props u_gsr_props (.core_clk(core_clk), .rst_b(rst_b),
		.bus_addr(lk.bus_addr), .bus_wr(lk.bus_wr), .bus_rd(lk.bus_rd),
		.bus_wdata(lk.bus_wdata), .bus_rdata(lk.bus_rdata),
		.bus_ack(lk.bus_ack), .host_interrupt_pin(lk.host_interrupt_pin));

	// ****************
	// Clock, counters and shared tasks
	// ****************
	// The clock toggles every half period of 200 MHz.
	always #2.5 core_clk = ~core_clk;

	// Update pulses are counted so a check can show a low-byte write does not commit.
	always @(posedge core_clk)
	begin
		if (temp_upd === 1'b1)
			n_tu <= n_tu + 1;
		if (hum_upd === 1'b1)
			n_hu <= n_hu + 1;
	end

	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One host request; the wait is bounded so a lost done cannot hang.
	task automatic op(input logic wr, input logic wide, input logic [7:0] a,
		input logic [15:0] wd);
		int n;
		@(posedge core_clk);
		req <= 1'b1;
		req_write <= wr;
		req_wide <= wide;
		req_addr <= a;
		req_wdata <= wd;
		@(posedge core_clk);
		req <= 1'b0;
		#1;
		chk("busy taken", 16'h0001, {15'h0000, busy});
		n = 0;
		while (done !== 1'b1 && n < 20)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n == 20)
			chk("done timeout", 16'h0001, 16'h0000);
		chk("busy ended", 16'h0000, {15'h0000, busy});
		v = rsp_rdata;
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		op(0, 0, 8'h20, 0);
		chk("state reset", 16'h0000, v);
		op(1, 0, 8'h21, 16'h00ff);
		op(0, 0, 8'h21, 0);
		chk("air index reset", 16'h0001, v);
		op(0, 1, 8'h26, 0);
		chk("relative index reset", 16'h0000, v);
		op(0, 1, 8'h13, 0);
		chk("temperature reset", 16'h0000, v);
		op(0, 0, 8'h30, 0);
		chk("unmapped read", 16'h0000, v);
	endtask

	task automatic t_status;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge core_clk);
			run <= i[0];
			err <= i[1];
			vld <= i[1:0];
			op(0, 0, 8'h20, 0);
			chk("state", {8'h00, i[0], i[1], 2'b00, i[1:0], 2'b00}, v);
		end
		@(posedge core_clk);
		run <= 1'b0;
		err <= 1'b0;
		vld <= 2'b00;
	endtask

	task automatic t_results;
		@(posedge core_clk);
		air <= 3'h4;
		org <= 16'h1234;
		co2 <= 16'h0190;
		rel <= 16'h01f4;
		rload <= 1'b1;
		@(posedge core_clk);
		rload <= 1'b0;
		op(0, 0, 8'h20, 0);
		chk("output flag set", 16'h0002, v);
		op(0, 0, 8'h21, 0);
		chk("air index", 16'h0004, v);
		op(0, 1, 8'h22, 0);
		chk("organic level", 16'h1234, v);
		op(0, 1, 8'h24, 0);
		chk("carbon dioxide", 16'h0190, v);
		op(0, 1, 8'h26, 0);
		chk("relative index", 16'h01f4, v);
		op(0, 0, 8'h20, 0);
		chk("output flag cleared", 16'h0000, v);
	endtask

	task automatic t_comp;
		op(1, 0, 8'h13, 16'h0011);
		chk("temperature held", 16'h0000, temp_out);
		op(0, 0, 8'h13, 0);
		chk("temperature staged", 16'h0011, v);
		op(1, 0, 8'h14, 16'h004a);
		chk("temperature commit", 16'h4a11, temp_out);
		chk("temperature updates", 16'h0001, 16'(n_tu));
		op(1, 1, 8'h13, 16'h4a8a);
		chk("temperature word", 16'h4a8a, temp_out);
		op(1, 1, 8'h15, 16'h6400);
		chk("humidity word", 16'h6400, hum_out);
		chk("humidity updates", 16'h0001, 16'(n_hu));
		op(0, 0, 8'h16, 0);
		chk("humidity high", 16'h0064, v);
	endtask

	task automatic t_version;
		op(1, 0, `GSR_OFF_COMMAND, {8'h00, `GSR_CMD_VERSION});
		op(0, 0, 8'h20, 0);
		chk("no run outside idle", 16'h0000, v);
		chk("pin quiet", 16'h0000, {15'h0000, irq_seen});
		@(posedge core_clk);
		mode_sel <= `GSR_MODE_IDLE;
		op(0, 0, 8'h20, 0);
		chk("readback flag set", 16'h0001, v);
		chk("pin raised", 16'h0001, {15'h0000, irq_seen});
		op(0, 1, 8'h4c, 0);
		chk("major and minor", {VMIN, VMAJ}, v);
		op(0, 0, 8'h4e, 0);
		chk("release", {8'h00, VREL}, v);
		op(0, 0, 8'h20, 0);
		chk("readback flag cleared", 16'h0000, v);
	endtask

	task automatic t_clear;
		op(1, 0, `GSR_OFF_COMMAND, {8'h00, `GSR_CMD_CLEAR});
		op(0, 1, 8'h4c, 0);
		chk("cleared four five", 16'h0000, v);
		op(0, 0, 8'h4e, 0);
		chk("cleared six", 16'h0000, v);
	endtask

	// The pin is switched to active low on fresh results only, so both
	// the polarity and the output source are exercised at least once.
	task automatic t_irq;
		@(posedge core_clk);
		irq_rb <= 1'b0;
		irq_out <= 1'b1;
		irq_hi <= 1'b0;
		op(0, 0, 8'h20, 0);
		chk("pin idle high", 16'h0001, {15'h0000, irq_seen});
		@(posedge core_clk);
		rload <= 1'b1;
		@(posedge core_clk);
		rload <= 1'b0;
		op(0, 0, 8'h20, 0);
		chk("output flag again", 16'h0002, v);
		chk("pin active low", 16'h0000, {15'h0000, irq_seen});
		op(0, 0, 8'h21, 0);
		op(0, 0, 8'h20, 0);
		chk("output flag read off", 16'h0000, v);
		chk("pin released", 16'h0001, {15'h0000, irq_seen});
	endtask

	// Main sequence: reset for six cycles, then each scenario in turn.
	initial
	begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		t_reset();
		t_status();
		t_results();
		t_comp();
		t_version();
		t_clear();
		t_irq();
		results();
	end

	// Watchdog sized well above the roughly 220 cycles the scenarios need.
	initial
	begin
		repeat (5000) @(posedge core_clk);
		n_errors++;
		results();
	end
endmodule // tb
